// >>> logic/data_fault_status_capture.sv
// data fault syndrome register with secure and non-secure copies
`timescale 1ns/10ps
`default_nettype none
`include "fault_status_params.svh"

module data_fault_status_capture (
    input  wire logic                              clk,
    input  wire logic                              reset,
    input  wire logic                              long_format_flag,
    input  wire fault_status_pkg::coproc_req_type  coproc_req,
    input  wire fault_status_pkg::fault_report_type fault_report,
    output var  fault_status_pkg::coproc_resp_type coproc_resp,
    output var  logic                              fault_dropped
);

    // short code legality check; anything not listed is reserved and never stored
    function automatic logic short_code_ok(input logic [4:0] fs);
        unique case (fs)
            // alignment, debug, access flag, cache maintenance, translation
            `FS_ALIGN,
            `FS_DEBUG,
            `FS_AF_SECT,
            `FS_ICACHE_MAINT,
            `FS_TRANS_SECT,
            `FS_AF_PAGE,
            `FS_TRANS_PAGE : short_code_ok = 1'b1;
            // external aborts, domain and permission faults
            `FS_SYNC_EXT,
            `FS_DOM_SECT,
            `FS_DOM_PAGE,
            `FS_EXT_WALK1,
            `FS_PERM_SECT,
            `FS_EXT_WALK2,
            `FS_PERM_PAGE : short_code_ok = 1'b1;
            // conflict, exclusive access, asynchronous external abort and parity reports
            `FS_TLB_CONFLICT,
            `FS_EXCL_ABORT,
            `FS_ASYNC_EXT,
            `FS_ASYNC_PARITY,
            `FS_SYNC_PARITY,
            `FS_PAR_WALK1,
            `FS_PAR_WALK2 : short_code_ok = 1'b1;
            default : short_code_ok = 1'b0;
        endcase
    endfunction : short_code_ok

    // lookup level check shared by every level-carrying long code
    function automatic logic level_ok(input logic [1:0] lvl);
        level_ok = (lvl != `LEVEL_RESERVED);
    endfunction : level_ok

    // long code legality check, level groups matched with the low bits cleared
    function automatic logic long_code_ok(input logic [5:0] st);
        unique case ({st[5:2], 2'h0})
            // translation, access flag and permission faults carry a level
            `LS_TRANS,
            `LS_ACCESS_FLAG,
            `LS_PERM : long_code_ok = level_ok(st[1:0]);
            // table walk external abort carries a level
            `LS_EXT_WALK : long_code_ok = level_ok(st[1:0]);
            // table walk parity error carries a level
            `LS_PAR_WALK : long_code_ok = level_ok(st[1:0]);
            default : begin
                // the remaining codes are single encodings
                unique case (st)
                    `LS_ADDR_SIZE : long_code_ok = 1'b1;
                    `LS_SYNC_EXT,
                    `LS_ASYNC_EXT : long_code_ok = 1'b1;
                    `LS_SYNC_PARITY,
                    `LS_ASYNC_PARITY : long_code_ok = 1'b1;
                    `LS_ALIGN,
                    `LS_DEBUG,
                    `LS_TLB_CONFLICT,
                    `LS_EXCL_ABORT : long_code_ok = 1'b1;
                    default : long_code_ok = 1'b0;
                endcase
            end
        endcase
    endfunction : long_code_ok

    // fields shared by both layouts
    function automatic logic [31:0] common_fields(input fault_status_pkg::fault_report_type f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`BIT_CACHE_MAINT] = f.synchronous & f.cache_maint;
        w[`BIT_EXT_KIND]    = f.is_external & f.slave_error;
        w[`BIT_WRITE]       = f.is_write | f.cache_maint;
        w[`BIT_LONG_FMT]    = f.long_format;
        common_fields = w;
    endfunction : common_fields

    // short layout: split fault code and domain
    function automatic logic [31:0] short_fields(input fault_status_pkg::fault_report_type f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`BIT_SHORT_FS4]   = f.code[4];
        w[`DOMAIN_LSB +: 4] = f.domain;
        w[3:0]              = f.code[3:0];
        short_fields = w;
    endfunction : short_fields

    // long layout: six-bit status code, level in its low bits
    function automatic logic [31:0] long_fields(input fault_status_pkg::fault_report_type f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[5:0] = f.code;
        long_fields = w;
    endfunction : long_fields

    // whole syndrome word for a legal fault in its own layout
    function automatic logic [31:0] build_syndrome(input fault_status_pkg::fault_report_type f);
        if (f.long_format) begin
            build_syndrome = common_fields(f) | long_fields(f);
        end else begin
            build_syndrome = common_fields(f) | short_fields(f);
        end
    endfunction : build_syndrome

    // one decode for both implemented encodings, so the two cannot drift apart
    function automatic logic hits_encoding(
        input fault_status_pkg::coproc_req_type r,
        input logic [2:0]                       opc1,
        input logic [3:0]                       crn,
        input logic [3:0]                       crm,
        input logic [2:0]                       opc2
    );
        hits_encoding = r.valid
                     && (r.coproc == `COPROC_NUM)
                     && (r.opc1 == opc1)
                     && (r.crn == crn)
                     && (r.crm == crm)
                     && (r.opc2 == opc2);
    endfunction : hits_encoding

    // bits that software may change in the layout now selected
    function automatic logic [31:0] layout_mask(input logic long_fmt);
        layout_mask = long_fmt ? `LONG_WMASK : `SHORT_WMASK;
    endfunction : layout_mask

    // next value of one copy: a fault beats a software write in the same cycle
    function automatic logic [31:0] copy_next(
        input logic [31:0]                        cur,
        input logic                               wr_hit,
        input logic [31:0]                        wr_value,
        input logic                               fault_hit,
        input fault_status_pkg::fault_report_type f
    );
        logic [31:0] v;
        v = cur;
        if (wr_hit) begin
            v = wr_value;
        end
        if (fault_hit) begin
            v = build_syndrome(f);
        end
        copy_next = v;
    endfunction : copy_next

    logic [31:0]                         secure_syn_reg;
    logic [31:0]                         secure_syn_next;
    logic [31:0]                         nonsecure_syn_reg;
    logic [31:0]                         nonsecure_syn_next;
    fault_status_pkg::coproc_resp_type   resp_next;
    logic                                dropped_next;
    logic                                fault_ok;
    logic                                fault_take;
    logic                                hit_syn;
    logic                                hit_hyp_aux_configuration;
    logic                                privileged;
    logic                                accepted;
    logic                                write_syn;
    logic                                wr_secure;
    logic                                wr_nonsecure;
    logic                                flt_secure;
    logic                                flt_nonsecure;
    logic [31:0]                         wmask;
    logic [31:0]                         wvalue;
    logic [31:0]                         read_copy;

    // transfer decode; only the two implemented encodings are accepted, and only when el is not 0
    always_comb begin
        hit_syn = hits_encoding(coproc_req, `SYN_OPC1, `SYN_CRN,
                                `SYN_CRM, `SYN_OPC2);
        hit_hyp_aux_configuration = hits_encoding(coproc_req, `HYP_AUX_CONFIGURATION_OPC1, `HYP_AUX_CONFIGURATION_CRN,
                                 `HYP_AUX_CONFIGURATION_CRM, `HYP_AUX_CONFIGURATION_OPC2);
        privileged = (coproc_req.el != 2'h0);
        accepted = privileged && (hit_syn || hit_hyp_aux_configuration);
        write_syn = accepted && hit_syn && coproc_req.write;
        // software write mask follows the current layout; reserved bits stay zero
        wmask = layout_mask(long_format_flag);
        wvalue = coproc_req.wdata & wmask;
        // the answer shows the copy as it stood before this cycle's write
        read_copy = coproc_req.secure ? secure_syn_reg : nonsecure_syn_reg;
    end

    // fault legality; a reserved code is reported as dropped and never stored
    always_comb begin
        fault_ok = fault_report.long_format ? long_code_ok(fault_report.code)
                                            : short_code_ok(fault_report.code[4:0]);
        fault_take = fault_report.valid && fault_ok;
    end

    // steer software writes and fault captures to their own copy
    always_comb begin
        wr_secure = write_syn && coproc_req.secure;
        wr_nonsecure = write_syn && !coproc_req.secure;
        flt_secure = fault_take && fault_report.secure;
        flt_nonsecure = fault_take && !fault_report.secure;
    end

    // secure copy next value
    always_comb begin
        secure_syn_next = copy_next(secure_syn_reg,
                                    wr_secure,
                                    wvalue,
                                    flt_secure,
                                    fault_report);
    end

    // secure copy register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            secure_syn_reg <= `SYN_RESET;
        end else begin
            secure_syn_reg <= secure_syn_next;
        end
    end

    // non-secure copy next value
    always_comb begin
        nonsecure_syn_next = copy_next(nonsecure_syn_reg,
                                       wr_nonsecure,
                                       wvalue,
                                       flt_nonsecure,
                                       fault_report);
    end

    // non-secure copy register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nonsecure_syn_reg <= `SYN_RESET;
        end else begin
            nonsecure_syn_reg <= nonsecure_syn_next;
        end
    end

    // answer to a transfer, one cycle after it was taken
    always_comb begin
        resp_next = '0;
        if (coproc_req.valid) begin
            resp_next.valid = 1'b1;
            if (!accepted) begin
                resp_next.refused = 1'b1;
            end else if (hit_hyp_aux_configuration) begin
                resp_next.rdata = 32'h0000_0000;
            end else begin
                // format bit is returned as stored; nothing else reads it
                resp_next.rdata = read_copy;
            end
        end
    end

    // answer register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            coproc_resp <= '0;
        end else begin
            coproc_resp <= resp_next;
        end
    end

    // dropped report flag; one pulse for every reserved code seen
    always_comb begin
        dropped_next = fault_report.valid && !fault_ok;
    end

    // dropped flag register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_dropped <= 1'b0;
        end else begin
            fault_dropped <= dropped_next;
        end
    end

endmodule : data_fault_status_capture
`default_nettype wire

// >>> logic/fault_status_params.svh
// constants for the data fault syndrome capture block
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH

// coprocessor access encoding
`define COPROC_NUM          4'hF
`define SYN_OPC1            3'h0
`define SYN_CRN             4'h5
`define SYN_CRM             4'h0
`define SYN_OPC2            3'h0
`define HYP_AUX_CONFIGURATION_OPC1           3'h4
`define HYP_AUX_CONFIGURATION_CRN            4'h1
`define HYP_AUX_CONFIGURATION_CRM            4'h1
`define HYP_AUX_CONFIGURATION_OPC2           3'h7

// field positions
`define BIT_CACHE_MAINT     13
`define BIT_EXT_KIND        12
`define BIT_WRITE           11
`define BIT_SHORT_FS4       10
`define BIT_LONG_FMT        9
`define DOMAIN_LSB          4
`define SYN_RESET           32'h0000_0000

// writable bit masks per layout
`define SHORT_WMASK         32'h0000_3EFF
`define LONG_WMASK          32'h0000_3A3F

// short layout codes
`define FS_ALIGN            5'h01
`define FS_DEBUG            5'h02
`define FS_AF_SECT          5'h03
`define FS_ICACHE_MAINT     5'h04
`define FS_TRANS_SECT       5'h05
`define FS_AF_PAGE          5'h06
`define FS_TRANS_PAGE       5'h07
`define FS_SYNC_EXT         5'h08
`define FS_DOM_SECT         5'h09
`define FS_DOM_PAGE         5'h0B
`define FS_EXT_WALK1        5'h0C
`define FS_PERM_SECT        5'h0D
`define FS_EXT_WALK2        5'h0E
`define FS_PERM_PAGE        5'h0F
`define FS_TLB_CONFLICT     5'h10
`define FS_EXCL_ABORT       5'h15
`define FS_ASYNC_EXT        5'h16
`define FS_ASYNC_PARITY     5'h18
`define FS_SYNC_PARITY      5'h19
`define FS_PAR_WALK1        5'h1C
`define FS_PAR_WALK2        5'h1E

// long layout codes
`define LS_ADDR_SIZE        6'h00
`define LS_TRANS            6'h04
`define LS_ACCESS_FLAG      6'h08
`define LS_PERM             6'h0C
`define LS_SYNC_EXT         6'h10
`define LS_ASYNC_EXT        6'h11
`define LS_EXT_WALK         6'h14
`define LS_SYNC_PARITY      6'h18
`define LS_ASYNC_PARITY     6'h19
`define LS_PAR_WALK         6'h1C
`define LS_ALIGN            6'h21
`define LS_DEBUG            6'h22
`define LS_TLB_CONFLICT     6'h30
`define LS_EXCL_ABORT       6'h35
`define LEVEL_RESERVED      2'h0

`endif

// >>> logic/fault_status_pkg.sv
// types for the data fault syndrome capture block
package fault_status_pkg;

    // one coprocessor register transfer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [3:0]  coproc;
        logic [2:0]  opc1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  opc2;
        logic [31:0] wdata;
        logic [1:0]  el;
        logic        secure;
    } coproc_req_type;

    // one data fault report from the memory system
    typedef struct packed {
        logic       valid;
        logic       secure;
        logic       long_format;
        logic       is_external;
        logic       slave_error;
        logic       cache_maint;
        logic       is_write;
        logic       synchronous;
        logic [3:0] domain;
        logic [5:0] code;
    } fault_report_type;

    // answer to a transfer
    typedef struct packed {
        logic        valid;
        logic        refused;
        logic [31:0] rdata;
    } coproc_resp_type;

endpackage : fault_status_pkg

// >>> test/data_fault_status_capture_chk.sv
// assertion checker for the data fault syndrome capture block
`timescale 1ns/10ps
`default_nettype none
`include "fault_status_params.svh"
module data_fault_status_capture_chk (
    input wire logic                               clk,
    input wire logic                               reset,
    input wire logic                               long_format_flag,
    input wire fault_status_pkg::coproc_req_type   coproc_req,
    input wire fault_status_pkg::fault_report_type fault_report,
    input wire fault_status_pkg::coproc_resp_type  coproc_resp,
    input wire logic                               fault_dropped
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // decoded transfer target, shared by the access properties
    logic [17:0] enc;
    logic        syn;
    logic        hyp;
    assign enc = {coproc_req.coproc, coproc_req.opc1, coproc_req.crn, coproc_req.crm,
                  coproc_req.opc2};
    assign syn = enc == {`COPROC_NUM, `SYN_OPC1, `SYN_CRN, `SYN_CRM, `SYN_OPC2};
    assign hyp = enc == {`COPROC_NUM, `HYP_AUX_CONFIGURATION_OPC1, `HYP_AUX_CONFIGURATION_CRN, `HYP_AUX_CONFIGURATION_CRM, `HYP_AUX_CONFIGURATION_OPC2};
    a_resp_next_cycle: assert property (coproc_req.valid |=> coproc_resp.valid)
        else $error("no answer one cycle after a transfer");
    a_no_idle_resp: assert property (!coproc_req.valid |=> !coproc_resp.valid)
        else $error("answer without a transfer");
    a_el0_refused: assert property (coproc_req.valid && coproc_req.el == 2'h0
        |=> coproc_resp.refused && coproc_resp.rdata == 32'h0) else $error("el0 not refused");
    a_hyp_aux_zero: assert property (coproc_req.valid && coproc_req.el != 2'h0 && hyp
        |=> !coproc_resp.refused && coproc_resp.rdata == 32'h0) else $error("hyp aux not zero");
    a_bad_enc_refused: assert property (coproc_req.valid && !syn && !hyp
        |=> coproc_resp.refused) else $error("unknown encoding accepted");
    a_rsvd_high_zero: assert property (coproc_resp.valid
        |-> coproc_resp.rdata[31:14] == 18'h0) else $error("reserved high bits set");
    a_level_zero_drop: assert property (fault_report.valid && fault_report.long_format
        && fault_report.code[5:4] == 2'h0 && fault_report.code[3:2] != 2'h0
        && fault_report.code[1:0] == 2'h0 |=> fault_dropped) else $error("level 0 kept");
    a_short_rsvd_drop: assert property (fault_report.valid && !fault_report.long_format
        && fault_report.code == 6'h00 |=> fault_dropped) else $error("reserved code kept");
    a_align_kept: assert property (fault_report.valid && fault_report.long_format
        && fault_report.code == `LS_ALIGN |=> !fault_dropped) else $error("alignment dropped");
    // main scenarios seen at least once
    c_write: cover property (coproc_req.valid && coproc_req.write && syn);
    c_drop: cover property (fault_dropped);
    c_long: cover property (fault_report.valid && fault_report.long_format);
    c_collide: cover property (coproc_req.valid && coproc_req.write && syn && fault_report.valid);
endmodule : data_fault_status_capture_chk
bind data_fault_status_capture data_fault_status_capture_chk chk_i (.clk(clk), .reset(reset),
    .long_format_flag(long_format_flag), .coproc_req(coproc_req),
    .fault_report(fault_report), .coproc_resp(coproc_resp), .fault_dropped(fault_dropped));
`default_nettype wire

// >>> test/data_fault_status_capture_tb_top.sv
// self-checking bench for the data fault syndrome capture block
`timescale 1ns/10ps
`default_nettype none
`include "fault_status_params.svh"
module data_fault_status_capture_tb_top;
    localparam logic [17:0] SYN = {`COPROC_NUM, `SYN_OPC1, `SYN_CRN, `SYN_CRM, `SYN_OPC2};
    localparam logic [17:0] HYP = {`COPROC_NUM, `HYP_AUX_CONFIGURATION_OPC1, `HYP_AUX_CONFIGURATION_CRN, `HYP_AUX_CONFIGURATION_CRM, `HYP_AUX_CONFIGURATION_OPC2};
    logic                               clk = 1'b0;
    logic                               reset = 1'b1;
    logic                               lf = 1'b0;
    fault_status_pkg::coproc_req_type   req = '0;
    fault_status_pkg::fault_report_type rep = '0;
    fault_status_pkg::coproc_resp_type  resp;
    logic                               drop;
    logic [31:0]                        m [2];
    int                                 n_errors = 0;
    int                                 n_compared = 0;
    // free-running 100 MHz clock
    always #5 clk = ~clk;
    data_fault_status_capture dut (.clk(clk), .reset(reset), .long_format_flag(lf),
        .coproc_req(req), .fault_report(rep), .coproc_resp(resp), .fault_dropped(drop));
    // syndrome expected from a legal fault
    function automatic logic [31:0] syn_of(input fault_status_pkg::fault_report_type f);
        logic [31:0] s;
        s = 32'h0;
        s[13] = f.synchronous & f.cache_maint;
        s[12] = f.is_external & f.slave_error;
        s[11] = f.is_write | f.cache_maint;
        s[9] = f.long_format;
        if (f.long_format) begin
            s[5:0] = f.code;
        end else begin
            s[10] = f.code[4];
            s[7:4] = f.domain;
            s[3:0] = f.code[3:0];
        end
        return s;
    endfunction : syn_of
    // listed codes only; bit i of the mask marks short code i
    function automatic logic legal(input fault_status_pkg::fault_report_type f);
        logic [31:0] sm;
        sm = 32'h5361_FBFE;
        if (!f.long_format) return !f.code[5] && sm[f.code[4:0]];
        case (f.code)
            6'h00, 6'h10, 6'h11, 6'h18, 6'h19, 6'h21, 6'h22, 6'h30, 6'h35: return 1'b1;
            default: return f.code[1:0] != 2'h0 && (f.code[5:2] == 4'h5
                || f.code[5:2] == 4'h7 || (f.code[5:4] == 2'h0 && f.code[3:2] != 2'h0));
        endcase
    endfunction : legal
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (!ok) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    // one transfer; the answer carries the value from before any write
    task automatic acc(input logic w, input logic s, input logic [1:0] el,
                       input logic [17:0] enc, input logic [31:0] wd);
        logic        rf;
        logic [31:0] ex;
        rf = el == 2'h0 || (enc != SYN && enc != HYP);
        ex = (rf || enc == HYP) ? 32'h0 : m[s];
        @(posedge clk);
        req <= {1'b1, w, enc, wd, el, s};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk(resp === {1'b1, rf, ex}, "transfer answer");
        if (w && !rf && enc == SYN) m[s] = wd & (lf ? `LONG_WMASK : `SHORT_WMASK);
    endtask : acc
    // one fault report, then read its copy back
    task automatic flt(input fault_status_pkg::fault_report_type f);
        logic ok;
        ok = legal(f);
        @(posedge clk);
        rep <= f;
        @(posedge clk);
        rep.valid <= 1'b0;
        #1;
        chk(drop === !ok, "drop flag");
        if (ok) m[f.secure] = syn_of(f);
        acc(1'b0, f.secure, 2'h1, SYN, 32'h0);
    endtask : flt
    task automatic give_verdict();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    // hang guard, far beyond the roughly 600 cycles of the run
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    // corner cases, every fault code, then random traffic
    initial begin
        fault_status_pkg::fault_report_type f;
        m = '{32'h0, 32'h0};
        void'($urandom(32'h6db4ed59));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        acc(1'b0, 1'b1, 2'h3, SYN, 32'h0);
        acc(1'b1, 1'b0, 2'h1, SYN, 32'hFFFF_FFFF);
        acc(1'b0, 1'b1, 2'h1, SYN, 32'h0);
        acc(1'b1, 1'b0, 2'h2, HYP, 32'hFFFF_FFFF);
        acc(1'b0, 1'b0, 2'h1, HYP, 32'h0);
        acc(1'b1, 1'b0, 2'h0, SYN, 32'h0);
        acc(1'b1, 1'b0, 2'h1, SYN ^ 18'h1, 32'h0);
        acc(1'b0, 1'b0, 2'h1, SYN, 32'h0);
        @(posedge clk) lf <= 1'b1;
        acc(1'b1, 1'b1, 2'h1, SYN, 32'hFFFF_FFFF);
        acc(1'b0, 1'b1, 2'h1, SYN, 32'h0);
        for (int i = 0; i < 96; i++) begin
            f = fault_status_pkg::fault_report_type'($urandom);
            f.valid = 1'b1;
            f.long_format = i >= 32;
            f.code = i >= 32 ? 6'(i - 32) : 6'(i);
            flt(f);
        end
        for (int i = 0; i < 60; i++) begin
            @(posedge clk) lf <= 1'($urandom);
            acc(1'($urandom), 1'($urandom), 2'($urandom), ($urandom % 3 == 0) ? HYP : SYN,
                $urandom);
        end
        // fault and write to one copy in one cycle: the fault wins
        f = '0;
        f.valid = 1'b1;
        f.long_format = 1'b1;
        f.code = `LS_ALIGN;
        @(posedge clk);
        rep <= f;
        req <= {1'b1, 1'b1, SYN, 32'h0000_3A3F, 2'h1, 1'b0};
        @(posedge clk);
        rep.valid <= 1'b0;
        req.valid <= 1'b0;
        #1;
        chk(resp === {1'b1, 1'b0, m[0]} && drop === 1'b0, "fault against write");
        m[0] = syn_of(f);
        acc(1'b0, 1'b0, 2'h1, SYN, 32'h0);
        // second reset in mid-run clears both copies
        @(posedge clk) reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        m = '{32'h0, 32'h0};
        acc(1'b0, 1'b0, 2'h1, SYN, 32'h0);
        acc(1'b0, 1'b1, 2'h1, SYN, 32'h0);
        give_verdict();
    end
endmodule : data_fault_status_capture_tb_top
`default_nettype wire
